/* File: hdl/scaler_fid_pkg.sv */
// Shared constants for the scaler field-id and horizontal-scaling block.
// Assumes a single 20 MHz pixel-side clock domain.
package scaler_fid_pkg;
  localparam int          DATA_W        = 8;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          PRESCALE_W    = 6;
  localparam int          INCREMENT_W   = 13;
  localparam int          ACCUM_W       = 6;
  localparam int          PHASE_W       = 15;
  localparam int          FRAC_BITS     = 6;
  localparam int          UNIT_LOG2     = 10;
  localparam logic [14:0] PHASE_UNIT    = 15'h0400;
  localparam int          SUM_W         = 14;
  localparam int          BIT_D7        = 7;
  localparam int          BIT_D6        = 6;
  localparam int          BIT_H         = 4;
  localparam logic [1:0]  PIN_SEL_LOW   = 2'h0;
  localparam logic [1:0]  PIN_SEL_FIELD = 2'h1;
  localparam logic [1:0]  PIN_SEL_TASK  = 2'h2;
  localparam logic        TASK_A        = 1'h0;
  localparam logic        TASK_B        = 1'h1;
  typedef enum logic [1:0] {FILL0 = 2'h0, FILL1 = 2'h1, RUN = 2'h3} fine_state_t;
endpackage

/* File: hdl/scaler_field_id.sv */
// Field-id and task-flag marking of the scaled stream, integer prescaler,
// 6-bit phase fine scaler and output FIFO.
// Assumes task and field strobes come from scaler logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none

module scaler_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0]   count, next_count;
  logic          push, pop;

  always_comb
  begin
    wr_ready   = (count != (AW+1)'(DEPTH));
    rd_valid   = (count != '0);
    push       = ce && wr_valid && wr_ready;
    pop        = ce && rd_valid && rd_ready;
    next_wptr  = push ? wptr + 1'b1 : wptr;
    next_rptr  = pop ? rptr + 1'b1 : rptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wptr] <= wr_data;
  end

  assign rd_data = mem[rptr];
endmodule // scaler_fifo

module scaler_field_id
  import scaler_fid_pkg::*;
#(
  parameter int DW    = scaler_fid_pkg::DATA_W,
  parameter int DEPTH = scaler_fid_pkg::FIFO_DEPTH
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst,
  input  wire logic                                   ce,
  input  wire logic                                   task_start,
  input  wire logic                                   task_select,
  input  wire logic                                   field_start,
  input  wire logic                                   field_output,
  input  wire logic                                   field_identifier,
  input  wire logic [1:0]                             output_field_id_select,
  input  wire logic [1:0]                             timing_code_bit7_invert,
  input  wire logic [1:0]                             pin_a_select,
  input  wire logic [1:0]                             pin_b_select,
  input  wire logic [scaler_fid_pkg::PRESCALE_W-1:0]  integer_prescale_ratio,
  input  wire logic [scaler_fid_pkg::INCREMENT_W-1:0] fine_scale_increment,
  input  wire logic [scaler_fid_pkg::ACCUM_W-1:0]     accumulation_length,
  input  wire logic                                   in_valid,
  output logic                                        in_ready,
  input  wire logic [DW-1:0]                          in_data,
  output logic                                        out_valid,
  input  wire logic                                   out_ready,
  output logic [DW-1:0]                               out_data,
  output logic [7:0]                                  sav_code,
  output logic [7:0]                                  eav_code,
  output logic                                        field_id_out,
  output logic                                        task_flag_out,
  output logic                                        general_output_pin_a,
  output logic                                        general_output_pin_b
);
  import scaler_fid_pkg::*;

  // Field marking
  logic toggle_a, toggle_b, next_toggle_a, next_toggle_b;
  logic active_task, next_active_task;
  logic next_field_id_out, next_task_flag_out, next_pin_a, next_pin_b;
  logic parity_now;

  always_comb
  begin
    next_toggle_a    = toggle_a;
    next_toggle_b    = toggle_b;
    next_active_task = active_task;
    if (task_start)
    begin
      next_active_task = task_select;
      // Flips on activation only; input field id never touches it
      if (task_select == TASK_A) next_toggle_a = ~toggle_a;
      else next_toggle_b = ~toggle_b;
    end
    parity_now         = (next_active_task == TASK_B) ? next_toggle_b : next_toggle_a;
    next_field_id_out  = field_id_out;
    next_task_flag_out = task_flag_out;
    // Skipped fields keep the previous marking
    if (field_start && field_output)
    begin
      next_field_id_out  = output_field_id_select[next_active_task] ? parity_now
                                                                    : field_identifier;
      next_task_flag_out = ~timing_code_bit7_invert[next_active_task];
    end
    next_pin_a = (pin_a_select == PIN_SEL_FIELD) ? next_field_id_out
               : (pin_a_select == PIN_SEL_TASK) ? next_task_flag_out : 1'b0;
    next_pin_b = (pin_b_select == PIN_SEL_FIELD) ? next_field_id_out
               : (pin_b_select == PIN_SEL_TASK) ? next_task_flag_out : 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      toggle_a             <= 1'b0;
      toggle_b             <= 1'b0;
      active_task          <= TASK_B;
      field_id_out         <= 1'b0;
      task_flag_out        <= 1'b1;
      general_output_pin_a <= 1'b0;
      general_output_pin_b <= 1'b0;
    end
    else if (ce)
    begin
      toggle_a             <= next_toggle_a;
      toggle_b             <= next_toggle_b;
      active_task          <= next_active_task;
      field_id_out         <= next_field_id_out;
      task_flag_out        <= next_task_flag_out;
      general_output_pin_a <= next_pin_a;
      general_output_pin_b <= next_pin_b;
    end
  end

  always_comb
  begin
    sav_code                = 8'h00;
    sav_code[BIT_D7]        = task_flag_out;
    sav_code[BIT_D6]        = field_id_out;
    eav_code                = sav_code;
    eav_code[BIT_H]         = 1'b1;
  end

  // Integer prescaler: sums the first accumulation_length+1 samples of each group
  logic [PRESCALE_W-1:0] ps_cnt, next_ps_cnt;
  logic [SUM_W-1:0]      ps_sum, next_ps_sum;
  logic [DW-1:0]         ps_data, next_ps_data;
  logic                  ps_valid, next_ps_valid, ps_take, ps_last;
  logic                  fs_take;

  always_comb
  begin
    // Refuse words while frozen, or a taken word would be lost
    in_ready      = ce && (!ps_valid || fs_take);
    ps_take       = in_valid && in_ready;
    ps_last       = (ps_cnt + 1'b1 >= integer_prescale_ratio);
    next_ps_cnt   = ps_cnt;
    next_ps_sum   = ps_sum;
    next_ps_data  = ps_data;
    next_ps_valid = ps_valid && !fs_take;
    if (ps_take)
    begin
      if (ACCUM_W'(ps_cnt) <= accumulation_length)
        next_ps_sum = ps_sum + SUM_W'(in_data);
      if (ps_last)
      begin
        // Gain renormalisation lives downstream; saturate instead of wrap
        next_ps_data  = (next_ps_sum > SUM_W'({DW{1'b1}})) ? {DW{1'b1}} : next_ps_sum[DW-1:0];
        next_ps_valid = 1'b1;
        next_ps_sum   = '0;
        next_ps_cnt   = '0;
      end
      else
        next_ps_cnt = ps_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ps_cnt   <= '0;
      ps_sum   <= '0;
      ps_data  <= '0;
      ps_valid <= 1'b0;
    end
    else if (ce)
    begin
      ps_cnt   <= next_ps_cnt;
      ps_sum   <= next_ps_sum;
      ps_data  <= next_ps_data;
      ps_valid <= next_ps_valid;
    end
  end

  // Variable phase delay fine scaler; phase counts 1/1024 of an input pixel
  fine_state_t         fs_state, next_fs_state;
  logic [PHASE_W-1:0]  phase, next_phase;
  logic [DW-1:0]       prev_px, cur_px, next_prev_px, next_cur_px;
  logic                fs_emit, fifo_ready;
  logic [FRAC_BITS-1:0] frac;
  logic signed [DW+FRAC_BITS+1:0] delta;
  logic [DW-1:0]       interp;

  always_comb
  begin
    frac          = phase[UNIT_LOG2-1 -: FRAC_BITS];
    delta         = ($signed({2'b00, cur_px}) - $signed({2'b00, prev_px}))
                    * $signed({1'b0, frac});
    interp        = DW'($signed({2'b00, prev_px}) + (delta >>> FRAC_BITS));
    fs_emit       = (fs_state == RUN) && (phase < PHASE_UNIT) && fifo_ready;
    fs_take       = ps_valid && ((fs_state != RUN) || (phase >= PHASE_UNIT));
    next_fs_state = fs_state;
    next_phase    = phase;
    next_prev_px  = prev_px;
    next_cur_px   = cur_px;
    if (fs_take)
    begin
      next_prev_px = cur_px;
      next_cur_px  = ps_data;
      unique case (fs_state)
        FILL0: next_fs_state = FILL1;
        FILL1: next_fs_state = RUN;
        RUN:   next_phase    = phase - PHASE_UNIT;
      endcase
    end
    else if (fs_emit)
      next_phase = phase + PHASE_W'(fine_scale_increment);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fs_state <= FILL0;
      phase    <= '0;
      prev_px  <= '0;
      cur_px   <= '0;
    end
    else if (ce)
    begin
      fs_state <= next_fs_state;
      phase    <= next_phase;
      prev_px  <= next_prev_px;
      cur_px   <= next_cur_px;
    end
  end

  // Output buffer stalls the fine scaler, which stalls the prescaler
  scaler_fifo #(.W(DW), .DEPTH(DEPTH)) out_fifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .ce       (ce),
    .wr_valid (fs_emit),
    .wr_ready (fifo_ready),
    .wr_data  (interp),
    .rd_valid (out_valid),
    .rd_ready (out_ready),
    .rd_data  (out_data)
  );

  sequence s_task_a_start;
    ce && task_start && task_select == TASK_A;
  endsequence

  sequence s_field_skip;
    ce && field_start && !field_output && !task_start;
  endsequence

  a_toggle_a_flip: assert property (@(posedge sys_clk) disable iff (rst)
    s_task_a_start |=> toggle_a != $past(toggle_a)) else $error("task A parity did not flip");
  a_toggle_b_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(ce && task_start && task_select == TASK_B) |=> toggle_b == $past(toggle_b))
    else $error("task B parity changed without activation");
  a_skip_holds_id: assert property (@(posedge sys_clk) disable iff (rst)
    s_field_skip |=> $stable(field_id_out) && $stable(task_flag_out)) else $error("skipped field changed marking");
  a_field_id_src: assert property (@(posedge sys_clk) disable iff (rst)
    ce && field_start && field_output && !task_start && !output_field_id_select[active_task]
    |=> field_id_out == $past(field_identifier)) else $error("field id not taken from input");
  a_parity_src: assert property (@(posedge sys_clk) disable iff (rst)
    ce && field_start && field_output && !task_start && output_field_id_select[active_task]
    |=> field_id_out == (active_task ? toggle_b : toggle_a)) else $error("field id not parity");
  a_bit7_value: assert property (@(posedge sys_clk) disable iff (rst)
    ce && field_start && field_output && !task_start
    |=> sav_code[BIT_D7] == !$past(timing_code_bit7_invert[active_task])) else $error("D7 wrong");
  a_pin_task: assert property (@(posedge sys_clk) disable iff (rst)
    ce && pin_a_select == PIN_SEL_TASK |=> general_output_pin_a == task_flag_out) else $error("pin a task flag");
  a_field_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !field_start ##1 1 |-> $stable(sav_code)) else $error("timing code changed inside field");
  a_phase_step: assert property (@(posedge sys_clk) disable iff (rst)
    ce && fs_emit |=> phase == $past(phase) + PHASE_W'($past(fine_scale_increment)))
    else $error("phase step wrong");
  a_phase_bound: assert property (@(posedge sys_clk) disable iff (rst)
    fs_emit |-> (interp >= prev_px && interp <= cur_px) || (interp <= prev_px && interp >= cur_px))
    else $error("interpolated sample outside its neighbours");
endmodule // scaler_field_id
`default_nettype wire

/* File: sim/backend_sink.sv */
// Far-side model: back-end logic that takes the scaled words, stalling at random.
// Assumes out_valid holds its word until it is taken.
`timescale 1ns/1ns
`default_nettype none
module backend_sink (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       hold,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  output logic            out_ready,
  output logic            got,
  output logic [7:0]      got_data
);
  logic [15:0] lfsr;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lfsr      <= 16'hace1;
      out_ready <= 1'b0;
      got       <= 1'b0;
      got_data  <= 8'h00;
    end
    else
    begin
      lfsr      <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      // Stalls one cycle in four, so the buffer sees backpressure
      out_ready <= !hold && (lfsr[1:0] != 2'h0);
      got       <= out_valid && out_ready;
      got_data  <= out_data;
    end
  end
endmodule // backend_sink
`default_nettype wire

/* File: sim/test_scaler_field_id.sv */
// Testbench for scaler_field_id: field marking, pins and the scaled stream.
// Assumes backend_sink as the back-end model on the output side.
`timescale 1ns/1ns
`default_nettype none
module test_scaler_field_id;
  import scaler_fid_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, hold = 1'b1;
  logic        task_start = 1'b0, task_select = 1'b0, field_start = 1'b0, field_output = 1'b0;
  logic        field_identifier = 1'b0, in_valid = 1'b0, ok;
  logic [1:0]  osel = 2'h0, inv = 2'h0, pa = 2'h0, pb = 2'h0, tog = 2'h0;
  logic [5:0]  ratio = 6'h01, acc = 6'h00;
  logic [12:0] inc = 13'h0400;
  logic [8:0]  sum9;
  logic [7:0]  in_data = 8'h00, out_data, got_data, sav, eav;
  logic        in_ready, out_valid, out_ready, got, fid_o, tf_o, pin_a, pin_b;
  logic        act = TASK_B, e_fid = 1'b0, e_tf = 1'b1;
  logic [19:0] mq[$];
  logic [7:0]  dq[$];
  logic [3:0]  fs_d = 4'h0;
  logic [31:0] seed = 32'hb3e4a240;
  int          mismatches = 0, total_checks = 0, n;

  scaler_field_id i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .task_start(task_start),
    .task_select(task_select), .field_start(field_start), .field_output(field_output),
    .field_identifier(field_identifier), .output_field_id_select(osel), .timing_code_bit7_invert(inv),
    .pin_a_select(pa), .pin_b_select(pb), .integer_prescale_ratio(ratio), .fine_scale_increment(inc),
    .accumulation_length(acc), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .sav_code(sav), .eav_code(eav),
    .field_id_out(fid_o), .task_flag_out(tf_o), .general_output_pin_a(pin_a), .general_output_pin_b(pin_b));

  backend_sink i_sink (.sys_clk(sys_clk), .rst(rst), .hold(hold), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .got(got), .got_data(got_data));

  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic pinv(input logic [1:0] s);
    return (s == PIN_SEL_FIELD) ? e_fid : (s == PIN_SEL_TASK) ? e_tf : 1'b0;
  endfunction

  task automatic check(input logic [19:0] got_v, input logic [19:0] exp_v);
    total_checks++;
    if (got_v !== exp_v)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One output or skipped field; marking checked by the monitor three edges later
  task automatic mark();
    seed = xs(seed);
    @(posedge sys_clk);
    {task_start, task_select, field_identifier, osel, inv, pa, pb} <= seed[10:0];
    field_output <= |seed[12:11];
    field_start <= 1'b1;
    @(posedge sys_clk);
    task_start <= 1'b0;
    field_start <= 1'b0;
    if (task_start)
    begin
      act = task_select;
      tog[task_select] = ~tog[task_select];
    end
    if (field_output)
    begin
      e_tf = ~inv[act];
      e_fid = osel[act] ? tog[act] : field_identifier;
    end
    mq.push_back({e_fid, e_tf, e_tf, e_fid, 6'h00, e_tf, e_fid, 6'h10, pinv(pa), pinv(pb)});
    repeat (4) @(posedge sys_clk);
  endtask

  // Holds the word for up to lim cycles, until in_ready sampled at the falling edge before a rising edge is high
  task automatic send(input logic [7:0] d, input int lim, output logic acc_ok);
    logic rdy;
    acc_ok = 1'b0;
    in_valid <= 1'b1;
    in_data <= d;
    for (int i = 0; i < lim && !acc_ok; i++)
    begin
      @(negedge sys_clk);
      rdy = in_ready;
      @(posedge sys_clk);
      acc_ok = rdy;
    end
    if (acc_ok)
      dq.push_back(d);
  endtask

  always @(posedge sys_clk)
  begin
    fs_d <= {fs_d[2:0], field_start};
    if (fs_d[2] && mq.size() > 0)
      check({fid_o, tf_o, sav, eav, pin_a, pin_b}, mq.pop_front());
    if (got && dq.size() > 0)
      check({12'h000, got_data}, {12'h000, dq.pop_front()});
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({fid_o, tf_o, sav, eav, pin_a, pin_b}, {1'b0, 1'b1, 8'h80, 8'h90, 2'b00});
    check({18'h0, out_valid, in_ready}, 20'h00001);
    @(posedge sys_clk);
    ce <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    // Frozen block must not accept input
    check({18'h0, out_valid, in_ready}, 20'h00000);
    @(posedge sys_clk);
    ce <= 1'b1;
    $display("test reset done");
    repeat (200) mark();
    $display("test marking done");
    // Ratio 1 and increment 1024 give one output per input
    n = 0;
    for (int i = 0; i < 60; i++)
    begin
      seed = xs(seed);
      send(seed[7:0], 20, ok);
      if (!ok)
        break;
      n++;
    end
    in_valid <= 1'b0;
    check({19'h0, n > FIFO_DEPTH}, 20'h00001);
    check({19'h0, out_valid}, 20'h00001);
    $display("test fill done");
    hold <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 20; i++)
    begin
      seed = xs(seed);
      send(seed[7:0], 200, ok);
    end
    in_valid <= 1'b0;
    for (int i = 0; i < 800 && dq.size() > 1; i++)
      @(posedge sys_clk);
    // Last word waits in the fine scaler for a successor
    check({12'h000, 8'(dq.size())}, 20'h00001);
    $display("test drain done");
    // Mid-run reset drops the parked word; ratio 3, window 2 sums two of three
    rst <= 1'b1;
    ratio <= 6'h03;
    acc <= 6'h01;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    dq.delete();
    @(posedge sys_clk);
    @(negedge sys_clk);
    check({18'h0, out_valid, in_ready}, 20'h00001);
    @(posedge sys_clk);
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      send(seed[7:0], 200, ok);
      send(seed[15:8], 200, ok);
      send(seed[23:16], 200, ok);
      sum9 = {1'b0, seed[7:0]} + {1'b0, seed[15:8]};
      repeat (3) void'(dq.pop_back());
      dq.push_back(sum9[8] ? 8'hff : sum9[7:0]);
    end
    in_valid <= 1'b0;
    for (int i = 0; i < 800 && dq.size() > 1; i++)
      @(posedge sys_clk);
    check({12'h000, 8'(dq.size())}, 20'h00001);
    $display("test prescale done");
    test_done();
  end
endmodule // test_scaler_field_id
`default_nettype wire
